// *** hw/bridge_window_defs.svh ***
/*
 * Register offsets, field positions and reset values of the bridge memory window registers.
 * Assumes inclusion by bare name from any design file that needs them.
 */
`ifndef BRIDGE_WINDOW_DEFS_SVH
`define BRIDGE_WINDOW_DEFS_SVH

`define OFS_NP_BOTTOM 8'h20
`define OFS_NP_TOP 8'h22
`define OFS_PF_BOTTOM 8'h24
`define OFS_PF_TOP 8'h26
`define OFS_PF_BOTTOM_HIGH 8'h28
`define OFS_PF_TOP_HIGH 8'h2c

`define FIELD_MSB 15
`define FIELD_LSB 4
`define CAP_BIT 0

`define RST_BOTTOM_FIELD 12'hfff
`define RST_TOP_FIELD 12'h000
`define RST_CAP 1'b1
`define RST_BOTTOM_HIGH 32'hffffffff
`define RST_TOP_HIGH 32'h00000000

`define LOW_ONES 20'hfffff
`define LOW_ZEROS 20'h00000

`endif

// *** hw/bridge_window_pkg.sv ***
/*
 * Types shared by the bridge memory window register bank and its helpers.
 * Assumes nothing of its surroundings.
 */
package bridge_window_pkg;
	typedef logic [7:0] cfg_addr_t;
	typedef logic [31:0] cfg_data_t;
	typedef logic [63:0] mem_addr_t;
	typedef logic [11:0] mb_field_t;
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_NP_BOTTOM,
		SEL_NP_TOP,
		SEL_PF_BOTTOM,
		SEL_PF_TOP,
		SEL_PF_BOTTOM_HIGH,
		SEL_PF_TOP_HIGH
	} reg_sel_e;
endpackage

// *** hw/window_if.sv ***
/*
 * Carrier for one assembled memory window: 64-bit base and limit.
 * Assumes the register bank drives it and a window comparator reads it.
 */
`timescale 1ns/1ps
interface window_if;
	bridge_window_pkg::mem_addr_t base;
	bridge_window_pkg::mem_addr_t limit;
	modport src(output base, output limit);
	modport dst(input base, input limit);
endinterface

// *** hw/addr_decode.sv ***
/*
 * Combinational decode of a configuration byte offset into a register select.
 * Assumes the offset is stable beside its strobe on the same clock.
 */
`timescale 1ns/1ps
`include "bridge_window_defs.svh"
module addr_decode (
	// Offset in, select out.
	input wire bridge_window_pkg::cfg_addr_t cfg_addr,
	output bridge_window_pkg::reg_sel_e sel
);
	import bridge_window_pkg::*;

	assign sel = (cfg_addr == `OFS_NP_BOTTOM) ? SEL_NP_BOTTOM :
		(cfg_addr == `OFS_NP_TOP) ? SEL_NP_TOP :
		(cfg_addr == `OFS_PF_BOTTOM) ? SEL_PF_BOTTOM :
		(cfg_addr == `OFS_PF_TOP) ? SEL_PF_TOP :
		(cfg_addr == `OFS_PF_BOTTOM_HIGH) ? SEL_PF_BOTTOM_HIGH :
		(cfg_addr == `OFS_PF_TOP_HIGH) ? SEL_PF_TOP_HIGH :
		SEL_NONE;
endmodule

// *** hw/window_match.sv ***
/*
 * Registered inside-window test of one transaction address against one window.
 * Assumes base and limit come from registers on the same clock.
 */
`timescale 1ns/1ps
module window_match (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Window bounds.
	window_if.dst win,
	// Query and answer.
	input wire bridge_window_pkg::mem_addr_t query_addr,
	input wire logic query_valid,
	output logic hit
);
	import bridge_window_pkg::*;

	logic in_range;
	logic hit_nxt;
	logic hit_r;

	assign in_range = (query_addr >= win.base) && (query_addr <= win.limit);
	assign hit_nxt = query_valid && in_range;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			hit_r <= 1'b0;
		end else begin
			hit_r <= hit_nxt;
		end
	end

	assign hit = hit_r;

	property p_hit_range;
		@(posedge ref_clk) disable iff (sys_rst)
		query_valid |=> hit == ($past(query_addr) >= $past(win.base) && $past(query_addr) <= $past(win.limit));
	endproperty
	a_hit_range: assert property (p_hit_range) else $error("Window hit disagrees with address range.");

	property p_empty_window;
		@(posedge ref_clk) disable iff (sys_rst)
		(win.base > win.limit) ##1 (win.base > win.limit) |-> !hit;
	endproperty
	a_empty_window: assert property (p_empty_window) else $error("Empty window reported a hit.");
endmodule

// *** hw/bridge_memory_window_regs.sv ***
/*
 * Memory window register bank of a bridge function: non-prefetchable bounds, prefetchable
 * bounds with upper words and the wide addressing capability, plus the forwarding decision.
 * Assumes a configuration master on the same clock that keeps its strobes one cycle long
 * and never raises both at once, and a lock input driven by logic on the same clock.
 */
// Added by the designer: the plain strobed port.
// Summary of operation
// - Non-prefetchable top field holds A[31:20], resets zero.
// - Window tops assume A[19:0] all ones.
// - Non-prefetchable bounds decide non-prefetchable forwarding.
// - Lockable capability bit selects 32/64-bit, resets one.
// - Prefetchable top bit 0 mirrors capability.
// - Prefetchable bottom field A[31:20], resets 0xfff.
// - Prefetchable top field A[31:20], resets zero.
// - Four prefetchable registers decide prefetchable forwarding.
// - Bottom high word gives A[63:32], resets ones.
// - Top high word gives A[63:32], resets zero.
// - Narrow mode makes high words zero, read-only.
// - Non-prefetchable bottom field A[31:20], resets 0xfff.
`timescale 1ns/1ps
`include "bridge_window_defs.svh"
module bridge_memory_window_regs (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Configuration register port.
	input wire bridge_window_pkg::cfg_addr_t cfg_addr,
	input wire bridge_window_pkg::cfg_data_t cfg_wdata,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	output bridge_window_pkg::cfg_data_t cfg_rdata,
	// Capability lock.
	input wire logic cap_lock,
	// Transaction address check.
	input wire bridge_window_pkg::mem_addr_t txn_addr,
	input wire logic txn_valid,
	output logic fwd_nonprefetch,
	output logic fwd_prefetch,
	// Mode status.
	output logic wide_prefetch_addressing
);
	import bridge_window_pkg::*;

	reg_sel_e sel;
	logic wr_np_bottom;
	logic wr_np_top;
	logic wr_pf_bottom;
	logic wr_pf_top;
	logic wr_cap;
	logic wr_pf_bottom_high;
	logic wr_pf_top_high;

	mb_field_t nonprefetch_window_bottom_r;
	mb_field_t nonprefetch_window_top_r;
	mb_field_t prefetch_window_bottom_r;
	mb_field_t prefetch_window_top_r;
	logic prefetch_wide_addr_capable_r;
	cfg_data_t prefetch_bottom_high_r;
	cfg_data_t prefetch_top_high_r;

	mb_field_t nonprefetch_window_bottom_nxt;
	mb_field_t nonprefetch_window_top_nxt;
	mb_field_t prefetch_window_bottom_nxt;
	mb_field_t prefetch_window_top_nxt;
	logic prefetch_wide_addr_capable_nxt;
	cfg_data_t prefetch_bottom_high_nxt;
	cfg_data_t prefetch_top_high_nxt;

	cfg_data_t bottom_high_view;
	cfg_data_t top_high_view;
	cfg_data_t np_bottom_rd;
	cfg_data_t np_top_rd;
	cfg_data_t pf_bottom_rd;
	cfg_data_t pf_top_rd;
	cfg_data_t rd_mux;
	cfg_data_t cfg_rdata_nxt;
	cfg_data_t cfg_rdata_r;
	logic wide_mode_r;

	window_if np_win ();
	window_if pf_win ();

	addr_decode u_decode (
		.cfg_addr(cfg_addr),
		.sel(sel)
	);

	// Write strobes per register.
	assign wr_np_bottom = cfg_wr && (sel == SEL_NP_BOTTOM);
	assign wr_np_top = cfg_wr && (sel == SEL_NP_TOP);
	assign wr_pf_bottom = cfg_wr && (sel == SEL_PF_BOTTOM);
	assign wr_pf_top = cfg_wr && (sel == SEL_PF_TOP);
	assign wr_cap = wr_pf_bottom && !cap_lock;
	assign wr_pf_bottom_high = cfg_wr && (sel == SEL_PF_BOTTOM_HIGH) && prefetch_wide_addr_capable_r;
	assign wr_pf_top_high = cfg_wr && (sel == SEL_PF_TOP_HIGH) && prefetch_wide_addr_capable_r;

	assign nonprefetch_window_bottom_nxt = wr_np_bottom ? cfg_wdata[`FIELD_MSB:`FIELD_LSB] :
		nonprefetch_window_bottom_r;
	assign nonprefetch_window_top_nxt = wr_np_top ? cfg_wdata[`FIELD_MSB:`FIELD_LSB] : nonprefetch_window_top_r;
	assign prefetch_window_bottom_nxt = wr_pf_bottom ? cfg_wdata[`FIELD_MSB:`FIELD_LSB] : prefetch_window_bottom_r;
	assign prefetch_window_top_nxt = wr_pf_top ? cfg_wdata[`FIELD_MSB:`FIELD_LSB] : prefetch_window_top_r;
	assign prefetch_wide_addr_capable_nxt = wr_cap ? cfg_wdata[`CAP_BIT] : prefetch_wide_addr_capable_r;

	// Clearing the stored words in narrow mode means a later return to wide mode starts from zero.
	// bottom and top high words
	assign prefetch_bottom_high_nxt = !prefetch_wide_addr_capable_r ? '0 :
		wr_pf_bottom_high ? cfg_wdata : prefetch_bottom_high_r;
	assign prefetch_top_high_nxt = !prefetch_wide_addr_capable_r ? '0 :
		wr_pf_top_high ? cfg_wdata : prefetch_top_high_r;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			nonprefetch_window_bottom_r <= `RST_BOTTOM_FIELD;
			nonprefetch_window_top_r <= `RST_TOP_FIELD;
			prefetch_window_bottom_r <= `RST_BOTTOM_FIELD;
			prefetch_window_top_r <= `RST_TOP_FIELD;
			prefetch_wide_addr_capable_r <= `RST_CAP;
		end else begin
			nonprefetch_window_bottom_r <= nonprefetch_window_bottom_nxt;
			nonprefetch_window_top_r <= nonprefetch_window_top_nxt;
			prefetch_window_bottom_r <= prefetch_window_bottom_nxt;
			prefetch_window_top_r <= prefetch_window_top_nxt;
			prefetch_wide_addr_capable_r <= prefetch_wide_addr_capable_nxt;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			prefetch_bottom_high_r <= `RST_BOTTOM_HIGH;
			prefetch_top_high_r <= `RST_TOP_HIGH;
		end else begin
			prefetch_bottom_high_r <= prefetch_bottom_high_nxt;
			prefetch_top_high_r <= prefetch_top_high_nxt;
		end
	end

	assign bottom_high_view = prefetch_wide_addr_capable_r ? prefetch_bottom_high_r : '0;
	assign top_high_view = prefetch_wide_addr_capable_r ? prefetch_top_high_r : '0;

	assign np_bottom_rd = {16'h0000, nonprefetch_window_bottom_r, 4'h0};
	assign np_top_rd = {16'h0000, nonprefetch_window_top_r, 4'h0};
	assign pf_bottom_rd = {16'h0000, prefetch_window_bottom_r, 3'h0, prefetch_wide_addr_capable_r};
	assign pf_top_rd = {16'h0000, prefetch_window_top_r, 3'h0, prefetch_wide_addr_capable_r};

	// Unmapped offsets read as zero so software probing the space sees nothing stale.
	assign rd_mux = (sel == SEL_NP_BOTTOM) ? np_bottom_rd :
		(sel == SEL_NP_TOP) ? np_top_rd :
		(sel == SEL_PF_BOTTOM) ? pf_bottom_rd :
		(sel == SEL_PF_TOP) ? pf_top_rd :
		(sel == SEL_PF_BOTTOM_HIGH) ? bottom_high_view :
		(sel == SEL_PF_TOP_HIGH) ? top_high_view :
		'0;
	assign cfg_rdata_nxt = cfg_rd ? rd_mux : '0;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cfg_rdata_r <= '0;
			wide_mode_r <= `RST_CAP;
		end else begin
			cfg_rdata_r <= cfg_rdata_nxt;
			wide_mode_r <= prefetch_wide_addr_capable_r;
		end
	end

	assign cfg_rdata = cfg_rdata_r;
	assign wide_prefetch_addressing = wide_mode_r;

	assign np_win.base = {32'h00000000, nonprefetch_window_bottom_r, `LOW_ZEROS};
	assign np_win.limit = {32'h00000000, nonprefetch_window_top_r, `LOW_ONES};
	assign pf_win.base = {bottom_high_view, prefetch_window_bottom_r, `LOW_ZEROS};
	assign pf_win.limit = {top_high_view, prefetch_window_top_r, `LOW_ONES};

	window_match u_np_match (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.win(np_win),
		.query_addr(txn_addr),
		.query_valid(txn_valid),
		.hit(fwd_nonprefetch)
	);

	window_match u_pf_match (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.win(pf_win),
		.query_addr(txn_addr),
		.query_valid(txn_valid),
		.hit(fwd_prefetch)
	);

	property p_np_top_write;
		@(posedge ref_clk) disable iff (sys_rst)
		(cfg_wr && cfg_addr == `OFS_NP_TOP) |=> nonprefetch_window_top_r == $past(cfg_wdata[`FIELD_MSB:`FIELD_LSB]);
	endproperty
	a_np_top_write: assert property (p_np_top_write) else $error("Top field did not take the write.");

	property p_low_ones;
		@(posedge ref_clk) disable iff (sys_rst)
		(np_win.limit[19:0] == `LOW_ONES) && (pf_win.limit[19:0] == `LOW_ONES) && (pf_win.base[19:0] == `LOW_ZEROS);
	endproperty
	a_low_ones: assert property (p_low_ones) else $error("Window low address bits are wrong.");

	property p_reset_values;
		@(posedge ref_clk) disable iff (sys_rst)
		$past(sys_rst) |-> nonprefetch_window_top_r == `RST_TOP_FIELD && prefetch_window_top_r == `RST_TOP_FIELD
			&& nonprefetch_window_bottom_r == `RST_BOTTOM_FIELD && prefetch_window_bottom_r == `RST_BOTTOM_FIELD
			&& prefetch_wide_addr_capable_r && prefetch_bottom_high_r == `RST_BOTTOM_HIGH
			&& prefetch_top_high_r == `RST_TOP_HIGH;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("Register reset value is wrong.");

	property p_cap_locked;
		@(posedge ref_clk) disable iff (sys_rst)
		(cap_lock && cfg_wr && cfg_addr == `OFS_PF_BOTTOM) |=> $stable(prefetch_wide_addr_capable_r);
	endproperty
	a_cap_locked: assert property (p_cap_locked) else $error("Locked capability bit changed.");

	property p_cap_mirror;
		@(posedge ref_clk) disable iff (sys_rst)
		(cfg_rd && cfg_addr == `OFS_PF_TOP) |=> cfg_rdata[`CAP_BIT] == $past(prefetch_wide_addr_capable_r);
	endproperty
	a_cap_mirror: assert property (p_cap_mirror) else $error("Top register bit 0 does not mirror capability.");

	property p_high_write;
		@(posedge ref_clk) disable iff (sys_rst)
		(cfg_wr && cfg_addr == `OFS_PF_BOTTOM_HIGH && prefetch_wide_addr_capable_r) |=>
			prefetch_bottom_high_r == $past(cfg_wdata);
	endproperty
	a_high_write: assert property (p_high_write) else $error("Bottom high word did not take the write.");

	property p_narrow_reads_zero;
		@(posedge ref_clk) disable iff (sys_rst)
		(cfg_rd && !prefetch_wide_addr_capable_r && (cfg_addr == `OFS_PF_BOTTOM_HIGH || cfg_addr == `OFS_PF_TOP_HIGH))
			|=> cfg_rdata == '0;
	endproperty
	a_narrow_reads_zero: assert property (p_narrow_reads_zero) else $error("High word not zero in narrow mode.");

	property p_reserved_zero;
		@(posedge ref_clk) disable iff (sys_rst)
		(cfg_rd && (cfg_addr == `OFS_NP_TOP || cfg_addr == `OFS_PF_BOTTOM)) |=> cfg_rdata[3:1] == 3'h0
			&& cfg_rdata[31:16] == 16'h0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits read nonzero.");

	property p_np_bottom_write;
		@(posedge ref_clk) disable iff (sys_rst)
		(cfg_wr && cfg_addr == `OFS_NP_BOTTOM) |=>
			nonprefetch_window_bottom_r == $past(cfg_wdata[`FIELD_MSB:`FIELD_LSB]);
	endproperty
	a_np_bottom_write: assert property (p_np_bottom_write) else $error("Bottom field did not take the write.");

	property p_pf_bottom_write;
		@(posedge ref_clk) disable iff (sys_rst)
		(cfg_wr && cfg_addr == `OFS_PF_BOTTOM) |=>
			prefetch_window_bottom_r == $past(cfg_wdata[`FIELD_MSB:`FIELD_LSB]);
	endproperty
	a_pf_bottom_write: assert property (p_pf_bottom_write) else $error("Bottom field lost its write.");

	property p_pf_top_write;
		@(posedge ref_clk) disable iff (sys_rst)
		(cfg_wr && cfg_addr == `OFS_PF_TOP) |=>
			prefetch_window_top_r == $past(cfg_wdata[`FIELD_MSB:`FIELD_LSB]);
	endproperty
	a_pf_top_write: assert property (p_pf_top_write) else $error("Top field lost its write.");

	property p_top_high_write;
		@(posedge ref_clk) disable iff (sys_rst)
		(cfg_wr && cfg_addr == `OFS_PF_TOP_HIGH && prefetch_wide_addr_capable_r) |=>
			prefetch_top_high_r == $past(cfg_wdata);
	endproperty
	a_top_high_write: assert property (p_top_high_write) else $error("Top high word did not take the write.");

	property p_narrow_high_clear;
		@(posedge ref_clk) disable iff (sys_rst)
		!prefetch_wide_addr_capable_r |=> prefetch_bottom_high_r == '0 && prefetch_top_high_r == '0;
	endproperty
	a_narrow_high_clear: assert property (p_narrow_high_clear) else $error("High words kept in narrow mode.");

	// The window is checked on the 12-bit fields, so a fault in the 64-bit assembly shows up here.
	property p_np_forward;
		@(posedge ref_clk) disable iff (sys_rst)
		txn_valid |=> fwd_nonprefetch == ($past(txn_addr[63:32]) == 32'h00000000
			&& $past(txn_addr[31:20]) >= $past(nonprefetch_window_bottom_r)
			&& $past(txn_addr[31:20]) <= $past(nonprefetch_window_top_r));
	endproperty
	a_np_forward: assert property (p_np_forward) else $error("Non-prefetchable forward decision is wrong.");

	property p_pf_forward;
		@(posedge ref_clk) disable iff (sys_rst)
		txn_valid |=> fwd_prefetch == (
			$past(txn_addr[63:20]) >= {$past(bottom_high_view), $past(prefetch_window_bottom_r)}
			&& $past(txn_addr[63:20]) <= {$past(top_high_view), $past(prefetch_window_top_r)});
	endproperty
	a_pf_forward: assert property (p_pf_forward) else $error("Prefetchable forward decision is wrong.");

	property p_wide_status;
		@(posedge ref_clk) disable iff (sys_rst)
		!$past(sys_rst) |-> wide_prefetch_addressing == $past(prefetch_wide_addr_capable_r);
	endproperty
	a_wide_status: assert property (p_wide_status) else $error("Mode status does not follow capability.");
endmodule

// *** tb/tb_bridge_memory_window_regs.sv ***
/*
 * Self-checking bench for the bridge memory window register bank.
 * Assumes the design files are compiled first and the window defines header is on the include path.
 */
`timescale 1ns/1ps
`include "bridge_window_defs.svh"
module tb_bridge_memory_window_regs;
	import bridge_window_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	cfg_addr_t cfg_addr = 8'h00;
	cfg_data_t cfg_wdata = 32'h0;
	logic cfg_wr = 1'b0;
	logic cfg_rd = 1'b0;
	cfg_data_t cfg_rdata;
	logic cap_lock = 1'b0;
	mem_addr_t txn_addr = 64'h0;
	logic txn_valid = 1'b0;
	logic fwd_nonprefetch;
	logic fwd_prefetch;
	logic wide_prefetch_addressing;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	cfg_addr_t ofs[6] = '{`OFS_NP_BOTTOM, `OFS_NP_TOP, `OFS_PF_BOTTOM, `OFS_PF_TOP, `OFS_PF_BOTTOM_HIGH,
		`OFS_PF_TOP_HIGH};
	cfg_data_t rst_val[6] = '{32'h0000fff0, 32'h0, 32'h0000fff1, 32'h00000001, 32'hffffffff, 32'h0};
	cfg_data_t ones_val[4] = '{32'h0000fff0, 32'h0000fff0, 32'h0000fff1, 32'h0000fff1};
	mem_addr_t q_addr[10] = '{64'h0000_0000_0100_0000, 64'h0000_0000_00ff_ffff, 64'h0000_0000_020f_ffff,
		64'h0000_0000_0210_0000, 64'h0000_0001_0100_0000, 64'h0000_0001_00ef_ffff, 64'h0000_0001_00f0_0000,
		64'h0000_0001_0fff_ffff, 64'h0000_0001_1000_0000, 64'h0000_0000_00f0_0000};
	logic q_np[10] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
	logic q_pf[10] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

	bridge_memory_window_regs u_dut (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.cfg_addr(cfg_addr),
		.cfg_wdata(cfg_wdata),
		.cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd),
		.cfg_rdata(cfg_rdata),
		.cap_lock(cap_lock),
		.txn_addr(txn_addr),
		.txn_valid(txn_valid),
		.fwd_nonprefetch(fwd_nonprefetch),
		.fwd_prefetch(fwd_prefetch),
		.wide_prefetch_addressing(wide_prefetch_addressing)
	);

	always #2.5 ref_clk = ~ref_clk;

	task automatic end_sim;
		if (failures == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk_data(input cfg_data_t got, input cfg_data_t exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic reg_wr(input cfg_addr_t a, input cfg_data_t d);
		@(posedge ref_clk);
		cfg_wr <= 1'b1;
		cfg_addr <= a;
		cfg_wdata <= d;
		@(posedge ref_clk);
		cfg_wr <= 1'b0;
	endtask

	// Read data are looked at only in the single cycle after the strobe.
	task automatic reg_rd(input cfg_addr_t a, input cfg_data_t exp);
		@(posedge ref_clk);
		cfg_rd <= 1'b1;
		cfg_addr <= a;
		@(posedge ref_clk);
		cfg_rd <= 1'b0;
		#1;
		chk_data(cfg_rdata, exp);
	endtask

	task automatic query(input mem_addr_t a, input logic np, input logic pf);
		@(posedge ref_clk);
		txn_valid <= 1'b1;
		txn_addr <= a;
		@(posedge ref_clk);
		txn_valid <= 1'b0;
		#1;
		chk_flag(fwd_nonprefetch, np);
		chk_flag(fwd_prefetch, pf);
	endtask

	// A hang is cut short well beyond the hundred or so cycles the sequence needs.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			end_sim();
		end
	end

	initial begin
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			reg_rd(ofs[i], rst_val[i]);
		end
		@(posedge ref_clk);
		#1;
		chk_data(cfg_rdata, 32'h0);
		chk_flag(wide_prefetch_addressing, 1'b1);
		query(64'h0, 1'b0, 1'b0);
		reg_wr(8'h30, 32'hffffffff);
		reg_rd(8'h30, 32'h0);
		reg_rd(8'h21, 32'h0);
		for (int i = 0; i < 4; i++) begin
			reg_wr(ofs[i], 32'hffffffff);
			reg_rd(ofs[i], ones_val[i]);
		end
		reg_wr(`OFS_NP_BOTTOM, 32'h00000100);
		reg_wr(`OFS_NP_TOP, 32'h00000200);
		reg_wr(`OFS_PF_BOTTOM, 32'h000000f1);
		reg_wr(`OFS_PF_TOP, 32'h00000ff0);
		reg_wr(`OFS_PF_BOTTOM_HIGH, 32'h00000001);
		reg_wr(`OFS_PF_TOP_HIGH, 32'h00000001);
		reg_rd(`OFS_PF_TOP, 32'h00000ff1);
		reg_rd(`OFS_PF_BOTTOM_HIGH, 32'h00000001);
		reg_rd(`OFS_PF_TOP_HIGH, 32'h00000001);
		for (int i = 0; i < 10; i++) begin
			query(q_addr[i], q_np[i], q_pf[i]);
		end
		reg_wr(`OFS_NP_BOTTOM, 32'h00000300);
		query(64'h0000_0000_0200_0000, 1'b0, 1'b0);
		@(posedge ref_clk);
		cap_lock <= 1'b1;
		reg_wr(`OFS_PF_BOTTOM, 32'h000000f0);
		reg_rd(`OFS_PF_BOTTOM, 32'h000000f1);
		@(posedge ref_clk);
		cap_lock <= 1'b0;
		reg_wr(`OFS_PF_BOTTOM, 32'h000000f0);
		reg_rd(`OFS_PF_BOTTOM, 32'h000000f0);
		reg_rd(`OFS_PF_TOP, 32'h00000ff0);
		reg_rd(`OFS_PF_BOTTOM_HIGH, 32'h0);
		reg_rd(`OFS_PF_TOP_HIGH, 32'h0);
		reg_wr(`OFS_PF_BOTTOM_HIGH, 32'h00000005);
		reg_rd(`OFS_PF_BOTTOM_HIGH, 32'h0);
		chk_flag(wide_prefetch_addressing, 1'b0);
		query(64'h0000_0000_00f0_0000, 1'b0, 1'b1);
		query(64'h0000_0001_00f0_0000, 1'b0, 1'b0);
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		reg_rd(`OFS_PF_BOTTOM, 32'h0000fff1);
		reg_rd(`OFS_PF_BOTTOM_HIGH, 32'hffffffff);
		reg_rd(`OFS_NP_BOTTOM, 32'h0000fff0);
		chk_flag(wide_prefetch_addressing, 1'b1);
		end_sim();
	end
endmodule
